// ==== design/edge_latch.sv ====
// rising-edge detector with a pending latch and clear
`timescale 1ns/1ps
module edge_latch
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// event side
	input wire logic reqIn,
	input wire logic clr,
	output logic pending
);
	logic prev_q;
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			prev_q <= 1'b0;
		else
			prev_q <= reqIn;
	end
	// a new edge wins over a clear in the same cycle
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pending <= 1'b0;
		else if (reqIn && !prev_q)
			pending <= 1'b1;
		else if (clr)
			pending <= 1'b0;
	end
endmodule // edge_latch

// ==== design/intc_cpu_end.sv ====
// processor-side end: takes requests at decode, saves state, fetches vector
`timescale 1ns/1ps
module intc_cpu_end
	import intc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// core pipeline
	input wire logic decodeValid,
	input wire logic [ADDR_W-1:0] pcIn,
	input wire logic [ADDR_W-1:0] statusIn,
	input wire logic [ADDR_W-1:0] vbrBase,
	// software mask load, e.g. on handler return
	input wire logic maskWr,
	input wire logic [LVL_W-1:0] maskWdata,
	// memory port
	output logic memWr,
	output logic memRd,
	output logic [ADDR_W-1:0] memAddr,
	output logic [ADDR_W-1:0] memWdata,
	input wire logic [ADDR_W-1:0] memRdata,
	input wire logic memDone,
	input wire logic [ADDR_W-1:0] stackPtr,
	// results
	output logic branchTake,
	output logic [ADDR_W-1:0] branchTarget,
	output logic [LVL_W-1:0] maskLevel,
	// controller side
	intc_if.cpu ctl
);
	typedef enum logic [2:0] {IDLE, PUSH_SR, PUSH_PC, FETCH, BRANCH} cpu_state_t;
	cpu_state_t state_q;
	logic [VEC_W-1:0] vec_q;
	assign ctl.cpuMaskLevel = maskLevel;
	assign ctl.intAck = (state_q == IDLE) && ctl.intReq && decodeValid;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_q <= IDLE;
			vec_q <= '0;
			maskLevel <= LVL_FIXED;
			memWr <= 1'b0;
			memRd <= 1'b0;
			memAddr <= '0;
			memWdata <= '0;
			branchTake <= 1'b0;
			branchTarget <= '0;
		end
		else
		begin
			branchTake <= 1'b0;
			unique case (state_q)
				IDLE:
					if (ctl.intAck)
					begin
						vec_q <= ctl.intVector;
						// nmi handler runs with the top mask
						maskLevel <= ctl.intNmi ? LVL_FIXED : ctl.intLevel;
						memWr <= 1'b1;
						memAddr <= stackPtr - 32'h0000_0004;
						memWdata <= statusIn;
						state_q <= PUSH_SR;
					end
					else if (maskWr)
						maskLevel <= maskWdata;
				PUSH_SR:
					if (memDone)
					begin
						memAddr <= stackPtr - 32'h0000_0008;
						memWdata <= pcIn;
						state_q <= PUSH_PC;
					end
				PUSH_PC:
					if (memDone)
					begin
						memWr <= 1'b0;
						memRd <= 1'b1;
						memAddr <= vbrBase + (ADDR_W'(vec_q) << SLOT_SHIFT);
						state_q <= FETCH;
					end
				FETCH:
					if (memDone)
					begin
						memRd <= 1'b0;
						branchTarget <= memRdata;
						state_q <= BRANCH;
					end
				BRANCH:
				begin
					branchTake <= 1'b1;
					state_q <= IDLE;
				end
			endcase
		end
	end
endmodule // intc_cpu_end

// ==== design/intc_ctrl.sv ====
// prioritizing vectored interrupt controller, device end
`timescale 1ns/1ps
module intc_ctrl
	import intc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic debugReset,
	// request sources
	input wire logic [NUM_PINS-1:0] extRequestPins,
	input wire logic [NUM_PINS-1:0] pinEdgeMode,
	input wire logic nmiPin,
	input wire logic breakReq,
	input wire logic debugReq,
	input wire logic [NUM_PERIPH-1:0] periphReq,
	// register port
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [2:0] regAddr,
	input wire logic [REG_W-1:0] regWdata,
	output logic [REG_W-1:0] regRdata,
	// processor side
	intc_if.ctrl cpu
);
	logic [REG_W-1:0] levelRegs_q [NUM_REGS];
	logic [NUM_PINS-1:0] pinEdgePend, flagSeen_q, pinClr, pinReq;
	logic nmiPend, breakPend, debugPend;
	logic nmiClr, breakClr, debugClr, latchRst_n;
	logic [NUM_SRC-1:0] reqVec;
	logic [LVL_W-1:0] lvlVec [NUM_SRC];
	logic [VEC_W-1:0] vecVec [NUM_SRC];
	logic [LVL_W-1:0] bestLvl;
	logic [VEC_W-1:0] bestVec;
	logic bestValid, bestNmi;
	logic busy_q;
	logic [VEC_W-1:0] heldVec_q;

	assign latchRst_n = rst_n && !debugReset;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			for (int i = 0; i < NUM_REGS; i++)
				levelRegs_q[i] <= LEVEL_RESET;
		else if (regWr && regAddr < REG_FLAGS)
			levelRegs_q[regAddr] <= regWdata;
	end

	// pin flags: edge latched, level mode follows the pin while low
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : pin_g
			edge_latch u_lat (
				.mclk(mclk),
				.rst_n(latchRst_n),
				.reqIn(!extRequestPins[g]),
				.clr(pinClr[g]),
				.pending(pinEdgePend[g])
			);
			assign pinReq[g] = pinEdgeMode[g] ? pinEdgePend[g] : !extRequestPins[g];
			assign pinClr[g] = (regWr && regAddr == REG_FLAGS && !regWdata[g] &&
				flagSeen_q[g]) || (busy_q && cpu.intAck &&
				heldVec_q == (g < 4 ? VEC_PIN_LO + VEC_W'(g) : VEC_PIN_HI + VEC_W'(g - 4)));
		end
	endgenerate

	// flag must have been read as one before a zero write cancels it
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			flagSeen_q <= '0;
		else if (regRd && regAddr == REG_FLAGS)
			flagSeen_q <= pinReq;
		else if (regWr && regAddr == REG_FLAGS)
			flagSeen_q <= '0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			regRdata <= '0;
		else if (regRd)
			regRdata <= (regAddr < REG_FLAGS) ? levelRegs_q[regAddr] :
				(regAddr == REG_FLAGS) ? {8'h00, pinReq} : '0;
	end

	assign nmiClr = busy_q && cpu.intAck && heldVec_q == VEC_NMI;
	assign breakClr = busy_q && cpu.intAck && heldVec_q == VEC_BREAK;
	assign debugClr = busy_q && cpu.intAck && heldVec_q == VEC_DEBUG;
	edge_latch u_nmi (.mclk(mclk), .rst_n(latchRst_n), .reqIn(nmiPin),
		.clr(nmiClr), .pending(nmiPend));
	edge_latch u_brk (.mclk(mclk), .rst_n(latchRst_n), .reqIn(breakReq),
		.clr(breakClr), .pending(breakPend));
	edge_latch u_dbg (.mclk(mclk), .rst_n(latchRst_n), .reqIn(debugReq),
		.clr(debugClr), .pending(debugPend));

	// source table in default order, index 0 highest except nmi (index 1), which beats all
	always_comb
	begin
		reqVec = '0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			lvlVec[i] = '0;
			vecVec[i] = '0;
		end
		reqVec[0] = breakPend;
		lvlVec[0] = LVL_FIXED;
		vecVec[0] = VEC_BREAK;
		reqVec[1] = nmiPend;
		lvlVec[1] = LVL_FIXED;
		vecVec[1] = VEC_NMI;
		reqVec[2] = debugPend;
		lvlVec[2] = LVL_FIXED;
		vecVec[2] = VEC_DEBUG;
		for (int p = 0; p < NUM_PINS; p++)
		begin
			reqVec[3+p] = pinReq[p];
			lvlVec[3+p] = levelRegs_q[p / 4][(15 - 4 * (p % 4)) -: 4];
			vecVec[3+p] = (p < 4) ? VEC_PIN_LO + VEC_W'(p) : VEC_PIN_HI + VEC_W'(p - 4);
		end
		reqVec[11] = periphReq[P_WDT];
		lvlVec[11] = levelRegs_q[REG_TIMER][15:12];
		vecVec[11] = VEC_WDT;
		reqVec[12] = periphReq[P_CMT0];
		lvlVec[12] = levelRegs_q[REG_TIMER][7:4];
		vecVec[12] = VEC_CMT;
		reqVec[13] = periphReq[P_CMT1];
		lvlVec[13] = levelRegs_q[REG_TIMER][3:0];
		vecVec[13] = VEC_CMT + 8'h01;
		for (int s = 0; s < 12; s++)
		begin
			reqVec[14+s] = periphReq[P_SER+s];
			lvlVec[14+s] = levelRegs_q[REG_SERIAL][(15 - 4 * (s / 4)) -: 4];
			vecVec[14+s] = VEC_SERIAL + VEC_W'(s);
		end
		reqVec[26] = periphReq[P_HOST];
		lvlVec[26] = levelRegs_q[REG_HOST][15:12];
		vecVec[26] = VEC_HOST;
		reqVec[27] = periphReq[P_HOSTB];
		lvlVec[27] = levelRegs_q[REG_HOST][11:8];
		vecVec[27] = VEC_HOST + 8'h01;
	end

	// highest level wins, nmi over all; strict compare keeps the earlier (smaller vector) on other ties
	always_comb
	begin
		bestValid = 1'b0;
		bestNmi = 1'b0;
		bestLvl = '0;
		bestVec = '0;
		for (int i = 0; i < NUM_SRC; i++)
			if (reqVec[i] && lvlVec[i] != 4'h0 &&
				(!bestValid || (!bestNmi && (i == 1 || lvlVec[i] > bestLvl))))
			begin
				bestValid = 1'b1;
				bestNmi = (i == 1);
				bestLvl = lvlVec[i];
				bestVec = vecVec[i];
			end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			busy_q <= 1'b0;
			heldVec_q <= '0;
			cpu.intReq <= 1'b0;
			cpu.intLevel <= '0;
			cpu.intVector <= '0;
			cpu.intNmi <= 1'b0;
		end
		else if (busy_q)
		begin
			if (cpu.intAck)
			begin
				busy_q <= 1'b0;
				cpu.intReq <= 1'b0;
			end
		end
		else if (bestValid && (bestNmi || bestLvl > cpu.cpuMaskLevel))
		begin
			busy_q <= 1'b1;
			heldVec_q <= bestVec;
			cpu.intReq <= 1'b1;
			cpu.intLevel <= bestLvl;
			cpu.intVector <= bestVec;
			cpu.intNmi <= bestNmi;
		end
	end
endmodule // intc_ctrl

// ==== design/intc_if.sv ====
// link between the controller and the processor core
`timescale 1ns/1ps
interface intc_if;
	import intc_pkg::*;
	logic intReq;
	logic [LVL_W-1:0] intLevel;
	logic [VEC_W-1:0] intVector;
	logic intNmi;
	logic [LVL_W-1:0] cpuMaskLevel;
	logic intAck;
	modport ctrl (output intReq, output intLevel, output intVector, output intNmi,
		input cpuMaskLevel, input intAck);
	modport cpu (input intReq, input intLevel, input intVector, input intNmi,
		output cpuMaskLevel, output intAck);
endinterface

// ==== design/intc_pkg.sv ====
// constants shared by the interrupt controller and the processor end
package intc_pkg;
	localparam int NUM_PINS = 8;
	localparam int NUM_SRC = 28;
	localparam int LVL_W = 4;
	localparam int VEC_W = 8;
	localparam int ADDR_W = 32;
	localparam int REG_W = 16;
	localparam int NUM_REGS = 5;
	// register indices
	localparam logic [2:0] REG_EXT_A = 3'h0;
	localparam logic [2:0] REG_EXT_B = 3'h1;
	localparam logic [2:0] REG_TIMER = 3'h2;
	localparam logic [2:0] REG_SERIAL = 3'h3;
	localparam logic [2:0] REG_HOST = 3'h4;
	localparam logic [2:0] REG_FLAGS = 3'h5;
	localparam logic [REG_W-1:0] LEVEL_RESET = 16'h0000;
	// fixed vectors
	localparam logic [VEC_W-1:0] VEC_NMI = 8'h0B;
	localparam logic [VEC_W-1:0] VEC_BREAK = 8'h0C;
	localparam logic [VEC_W-1:0] VEC_DEBUG = 8'h0D;
	localparam logic [VEC_W-1:0] VEC_PIN_LO = 8'h40;
	localparam logic [VEC_W-1:0] VEC_PIN_HI = 8'h50;
	localparam logic [VEC_W-1:0] VEC_WDT = 8'h54;
	localparam logic [VEC_W-1:0] VEC_CMT = 8'h56;
	localparam logic [VEC_W-1:0] VEC_SERIAL = 8'h58;
	localparam logic [VEC_W-1:0] VEC_HOST = 8'h64;
	localparam logic [LVL_W-1:0] LVL_FIXED = 4'hF;
	localparam int SLOT_SHIFT = 2;
	// peripheral request bit positions in the request vector
	localparam int P_WDT = 0;
	localparam int P_CMT0 = 1;
	localparam int P_CMT1 = 2;
	localparam int P_SER = 3;
	localparam int P_HOST = 15;
	localparam int P_HOSTB = 16;
	localparam int NUM_PERIPH = 17;
endpackage

// ==== sim/intc_properties.sv ====
// link checker between controller and processor end
`timescale 1ns/1ps
module intc_properties
	import intc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// link
	input wire logic intReq,
	input wire logic [LVL_W-1:0] intLevel,
	input wire logic [VEC_W-1:0] intVector,
	input wire logic intNmi,
	input wire logic [LVL_W-1:0] cpuMaskLevel,
	input wire logic intAck
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	hold_until_ack_a: assert property (
		intReq && !intAck |=> intReq && $stable(intLevel) && $stable(intVector))
		else $error("request changed before ack");
	ack_drops_a: assert property (intAck |=> !intReq)
		else $error("request held after ack");
	mask_compare_a: assert property (intReq && !intNmi |-> intLevel > cpuMaskLevel)
		else $error("request not above mask");
	level_zero_a: assert property (intReq |-> intLevel != 4'h0)
		else $error("level zero request");
	nmi_fixed_a: assert property (
		intReq && intNmi |-> intVector == VEC_NMI && intLevel == LVL_FIXED)
		else $error("nmi vector or level wrong");
	break_debug_level_a: assert property (
		intReq && (intVector == VEC_BREAK || intVector == VEC_DEBUG)
		|-> intLevel == LVL_FIXED && !intNmi)
		else $error("fixed source level wrong");
	vector_set_a: assert property (
		intReq |-> intVector inside
		{[8'h0B:8'h0D], [8'h40:8'h43], [8'h50:8'h54], [8'h56:8'h65]})
		else $error("vector outside table");
	ack_cause_a: assert property (intAck |-> intReq)
		else $error("ack without request");
	ack_pulse_a: assert property (intAck |=> !intAck)
		else $error("ack held past one cycle");
	mask_follow_a: assert property (intAck |=> cpuMaskLevel == $past(intLevel))
		else $error("mask not loaded from accepted level");
endmodule // intc_properties

// ==== sim/testbench.sv ====
// both ends joined, driven from core, pins and register port
`timescale 1ns/1ps
module testbench;
	import intc_pkg::*;
	logic mclk, rst_n, debugReset, nmiPin, breakReq, debugReq, regWr, regRd, decodeValid;
	logic [7:0] extRequestPins, pinEdgeMode;
	logic [NUM_PERIPH-1:0] periphReq;
	logic [2:0] regAddr;
	logic [15:0] regWdata, regRdata, rd;
	logic memWr, memRd, memDone, branchTake;
	logic [31:0] pcIn, statusIn, vbrBase, stackPtr, memAddr, memWdata, memRdata, branchTarget, ra;
	logic [3:0] maskLevel, maskWdata;
	logic maskWr;
	logic [31:0] wa[$], wd[$];
	int miscompares, nTests;
	intc_if i_intc_if ();
	intc_ctrl i_intc_ctrl (.mclk(mclk), .rst_n(rst_n), .debugReset(debugReset),
		.extRequestPins(extRequestPins), .pinEdgeMode(pinEdgeMode), .nmiPin(nmiPin),
		.breakReq(breakReq), .debugReq(debugReq), .periphReq(periphReq), .regWr(regWr),
		.regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.cpu(i_intc_if.ctrl));
	intc_cpu_end i_intc_cpu_end (.mclk(mclk), .rst_n(rst_n), .decodeValid(decodeValid),
		.maskWr(maskWr), .maskWdata(maskWdata),
		.pcIn(pcIn), .statusIn(statusIn), .vbrBase(vbrBase), .memWr(memWr), .memRd(memRd),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memDone(memDone),
		.stackPtr(stackPtr), .branchTake(branchTake), .branchTarget(branchTarget),
		.maskLevel(maskLevel), .ctl(i_intc_if.cpu));
	intc_properties i_intc_properties (.mclk(mclk), .rst_n(rst_n), .intReq(i_intc_if.intReq),
		.intLevel(i_intc_if.intLevel), .intVector(i_intc_if.intVector),
		.intNmi(i_intc_if.intNmi), .cpuMaskLevel(i_intc_if.cpuMaskLevel),
		.intAck(i_intc_if.intAck));
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// memory raises done on every other cycle while an access is pending, data tagged by address
	assign memRdata = {8'hA5, memAddr[23:0]};
	always @(negedge mclk) memDone <= (memWr | memRd) & !memDone;
	always @(posedge mclk)
	begin
		if (memWr && memDone) wa.push_back(memAddr);
		if (memWr && memDone) wd.push_back(memWdata);
		if (memRd && memDone) ra = memAddr;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		nTests++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task results;
		if (miscompares == 0 && nTests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task regW(input logic [2:0] a, input logic [15:0] d);
		@(negedge mclk);
		regWr = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge mclk);
		regWr = 1'b0;
	endtask
	task regR(input logic [2:0] a);
		@(negedge mclk);
		regRd = 1'b1;
		regAddr = a;
		@(negedge mclk);
		regRd = 1'b0;
		rd = regRdata;
	endtask
	task t_regs;
		for (int i = 0; i < 5; i++)
		begin
			regR(3'(i));
			chk(rd, 32'h0);
			regW(3'(i), 16'hA5C3 + 16'(i));
			regR(3'(i));
			chk(rd, 32'hA5C3 + i);
		end
		regR(3'h7);
		chk(rd, 32'h0);
		regW(REG_EXT_A, 16'hF000);
	endtask
	task t_nmi;
		int n;
		@(negedge mclk);
		nmiPin = 1'b1;
		@(negedge mclk);
		nmiPin = 1'b0;
		for (n = 0; n < 60 && branchTake !== 1'b1; n++) @(negedge mclk);
		if (n == 60)
		begin
			miscompares++;
			results();
		end
		chk(wa[0], stackPtr - 32'h4);
		chk(wd[0], statusIn);
		chk(wa[1], stackPtr - 32'h8);
		chk(wd[1], pcIn);
		chk(ra, vbrBase + 32'h2C);
		chk(branchTarget, {8'hA5, 24'h00102C});
		chk(32'(maskLevel), 32'hF);
	endtask
	task t_refuse;
		@(negedge mclk);
		breakReq = 1'b1;
		debugReq = 1'b1;
		@(negedge mclk);
		breakReq = 1'b0;
		debugReq = 1'b0;
		repeat (20)
		begin
			@(negedge mclk);
			chk(32'(i_intc_if.intReq), 32'h0);
		end
	endtask
	task t_pin;
		pinEdgeMode = 8'h01;
		for (int k = 0; k < 2; k++)
		begin
			@(negedge mclk);
			extRequestPins = 8'hFE;
			repeat (2) @(negedge mclk);
			extRequestPins = 8'hFF;
			regR(REG_FLAGS);
			chk(32'(rd), 32'h1);
			if (k == 0) regW(REG_FLAGS, 16'h0);
			else
			begin
				debugReset = 1'b1;
				@(negedge mclk);
				debugReset = 1'b0;
			end
			regR(REG_FLAGS);
			chk(32'(rd), 32'h0);
		end
	endtask
	// bounded wait for the handler branch, then check fetch, target and mask
	task takeBranch(input logic [31:0] slot, input logic [3:0] lvl);
		int n;
		for (n = 0; n < 60 && branchTake !== 1'b1; n++) @(negedge mclk);
		if (n == 60)
		begin
			miscompares++;
			results();
		end
		chk(ra, vbrBase + slot);
		chk(branchTarget, {8'hA5, 24'(vbrBase + slot)});
		chk(32'(maskLevel), 32'(lvl));
		@(negedge mclk);
		chk(32'(branchTake), 32'h0);
	endtask
	// levels left by t_regs: wdt A, cmt0 C, serial ch8 C, pin4 A, pin5 5, pin1 0
	task t_prio;
		@(negedge mclk);
		maskWr = 1'b1;
		maskWdata = 4'h4;
		@(negedge mclk);
		maskWr = 1'b0;
		periphReq[P_WDT] = 1'b1;
		periphReq[P_CMT0] = 1'b1;
		periphReq[P_SER + 8] = 1'b1;
		takeBranch(32'h158, 4'hC);
		repeat (5)
		begin
			@(negedge mclk);
			chk(32'(i_intc_if.intReq), 32'h0);
		end
		periphReq = '0;
		maskWr = 1'b1;
		maskWdata = 4'h0;
		extRequestPins = 8'hFD;
		@(negedge mclk);
		maskWr = 1'b0;
		repeat (5)
		begin
			@(negedge mclk);
			chk(32'(i_intc_if.intReq), 32'h0);
		end
		extRequestPins = 8'hCD;
		takeBranch(32'h140, 4'hA);
		repeat (3)
		begin
			@(negedge mclk);
			chk(32'(i_intc_if.intReq), 32'h0);
		end
		extRequestPins = 8'hFF;
	endtask
	initial
	begin
		{rst_n, debugReset, nmiPin, breakReq, debugReq, regWr, regRd, maskWr} = '0;
		extRequestPins = 8'hFF;
		pinEdgeMode = 8'h00;
		periphReq = '0;
		regAddr = 3'h0;
		regWdata = 16'h0;
		decodeValid = 1'b1;
		pcIn = 32'h200;
		statusIn = 32'hF0;
		vbrBase = 32'h1000;
		stackPtr = 32'h2000;
		maskWdata = 4'h0;
		miscompares = 0;
		nTests = 0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		t_regs();
		t_nmi();
		t_refuse();
		t_pin();
		t_prio();
		results();
	end
endmodule // testbench
